// ---- hdl/sfd_pkg.sv ----
// sfd_pkg: constants and types of the serial flash read and unlock slave
// assumes one 25 MHz system clock; all link pins are asynchronous to it
package sfd_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_INFO = 8'h68;
  localparam logic [7:0] OP_FDTR = 8'h0d;
  localparam logic [7:0] OP_DDTR = 8'hbd;
  localparam logic [7:0] OP_QDTR = 8'hed;
  localparam logic [7:0] OP_UNLK = 8'h26;
  localparam logic [7:0] OP_LOCK = 8'h24;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [3:0] MODE_CONT = 4'ha;

  // ==========================================================
  // frame lengths, in counted sck edges
  localparam logic [5:0] CMD_EDGES  = 6'h08;
  localparam logic [5:0] ADR_X1     = 6'h18;
  localparam logic [5:0] ADR_X2     = 6'h0c;
  localparam logic [5:0] ADR_X4     = 6'h06;
  localparam logic [5:0] INFO_DUMMY = 6'h08;
  localparam logic [5:0] FDTR_DUMMY = 6'h08;
  localparam logic [5:0] MODE_X2    = 6'h04;
  localparam logic [5:0] MODE_X4    = 6'h02;
  localparam logic [5:0] UNLK_EDGES = 6'h20;
  localparam logic [5:0] RCNT_MAX   = 6'h3f;
  localparam logic [11:0] SECT_OFS  = 12'h000;
  localparam logic [3:0] BYTE_BITS  = 4'h8;

  // ==========================================================
  // pad enables, low drives
  localparam logic [3:0] OE_OFF = 4'hf;
  localparam logic [3:0] OE_X1  = 4'hd;
  localparam logic [3:0] OE_X2  = 4'hc;
  localparam logic [3:0] OE_X4  = 4'h0;

  // ==========================================================
  // register map and reset values
  localparam logic [2:0] REG_STATUS  = 3'h0;
  localparam logic [2:0] REG_DUMMY   = 3'h1;
  localparam logic [2:0] REG_MPTR    = 3'h2;
  localparam logic [2:0] REG_MDATA   = 3'h3;
  localparam logic [2:0] REG_LOCK    = 3'h4;
  localparam logic [2:0] REG_SECT_HI = 3'h5;
  localparam logic [2:0] REG_SECT_LO = 3'h6;
  localparam logic [3:0] DDUMMY_RST  = 4'h2;
  localparam logic [3:0] QDUMMY_RST  = 4'h3;
  localparam int MEM_AW = 6;

  // ==========================================================
  // internal program time
  localparam int CLK_MHZ      = 25;
  localparam int PROG_TIME_US = 10;
  localparam int PROG_CYC     = PROG_TIME_US * CLK_MHZ;

  // ==========================================================
  // types
  typedef enum logic [1:0] {LN_1, LN_2, LN_4} sfd_lane_t;
  typedef enum logic [2:0] {
    S_IDLE, S_CMD, S_ADDR, S_DUMMY, S_DATA, S_HOLD, S_SKIP
  } sfd_state_t;
  typedef struct packed {
    logic       qe;
    logic [3:0] bp;
    logic       wel;
    logic       busy;
  } sfd_stat_t;
  typedef struct packed {
    logic [3:0] quad;
    logic [3:0] dual;
  } sfd_dcfg_t;

endpackage : sfd_pkg

// ---- hdl/sfd_top.sv ----
// sfd_top: serial flash slave for info-row read, double-rate reads, sector unlock
// assumes link pins asynchronous to ref_clk and sck well below ref_clk / 4
`timescale 1ns/10ps

// Overview of operation
// - info-row read is opcode 68h, three address bytes, one dummy byte, rising edges.
// - info-row read data leaves on the output line at falling sck edges.
// - info-row read address increments per byte and wraps to zero.
// - info-row read is ignored while busy; the running cycle is untouched.
// - single double-rate read 0Dh, then address two bits per clock, rise first.
// - single double-rate read has four dummy clocks, then data on both edges.
// - every double-rate read increments the address per byte, wrapping to zero.
// - raising chip enable ends a read and releases the data lines.
// - single double-rate read is rejected while busy.
// - dual read BDh sends address on lines 1 and 0, four bits per clock.
// - dual read has configurable dummy, two clocks by default, then dual data.
// - mode nibble A during dummy enters continuous mode; other values leave it.
// - dual double-rate read is rejected while busy.
// - quad read: four-line address, three dummy clocks default, four-line data.
// - quad double-rate read is rejected while busy.
// - sector unlock acts only when block-protect bits mark blocks protected.
// - sector unlock 26h takes 24-bit address; low twelve bits must be zero.
// - only one sector is unlocked at a time; relock before another.
// - sector unlock ignored unless the frame has exactly 8 plus 24 clocks.
// - busy reads one while the internal program runs, zero after.
module sfd_top (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       ce_b,
  input  wire logic       sck,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_b,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata
);

  // ==========================================================
  // helpers
  function automatic logic [3:0] sfd_bpe(input sfd_pkg::sfd_lane_t l);
    case (l)
      sfd_pkg::LN_2: sfd_bpe = 4'h2;
      sfd_pkg::LN_4: sfd_bpe = 4'h4;
      default:       sfd_bpe = 4'h1;
    endcase
  endfunction : sfd_bpe

  function automatic logic [3:0] sfd_lanes(input sfd_pkg::sfd_lane_t l,
                                           input logic [7:0] b);
    case (l)
      sfd_pkg::LN_2: sfd_lanes = {2'b00, b[7:6]};
      sfd_pkg::LN_4: sfd_lanes = b[7:4];
      default:       sfd_lanes = {2'b00, b[7], 1'b0};
    endcase
  endfunction : sfd_lanes

  function automatic logic [3:0] sfd_oe(input sfd_pkg::sfd_lane_t l);
    case (l)
      sfd_pkg::LN_2: sfd_oe = sfd_pkg::OE_X2;
      sfd_pkg::LN_4: sfd_oe = sfd_pkg::OE_X4;
      default:       sfd_oe = sfd_pkg::OE_X1;
    endcase
  endfunction : sfd_oe

  function automatic logic [23:0] sfd_shin(input sfd_pkg::sfd_lane_t l,
                                           input logic [23:0] a,
                                           input logic [3:0] d);
    case (l)
      sfd_pkg::LN_2: sfd_shin = {a[21:0], d[1:0]};
      sfd_pkg::LN_4: sfd_shin = {a[19:0], d};
      default:       sfd_shin = {a[22:0], d[0]};
    endcase
  endfunction : sfd_shin

  // ==========================================================
  // declarations
  logic [2:0]          sck_s;
  logic [1:0]          ce_s;
  logic                ce_q;
  logic [3:0]          io_m;
  logic [3:0]          io_s;
  logic                rise;
  logic                fall;
  logic                ce_fall;
  logic                ce_rise;
  logic                in_edge;
  logic                out_edge;
  sfd_pkg::sfd_state_t st;
  sfd_pkg::sfd_lane_t  ln;
  sfd_pkg::sfd_lane_t  cont_ln;
  logic                dtr;
  logic                cont;
  logic [7:0]          cmd;
  logic [7:0]          cmd_n;
  logic [5:0]          ecnt;
  logic [5:0]          rcnt;
  logic [5:0]          alen;
  logic [5:0]          dlen;
  logic [5:0]          mlen;
  logic [23:0]         adr;
  logic [23:0]         adr_n;
  logic [23:0]         adr_in;
  logic [23:0]         mode_w;
  logic [7:0]          mode;
  logic [7:0]          mode_f;
  logic [7:0]          sh;
  logic [3:0]          nb;
  logic [3:0]          bpe;
  logic [7:0]          cur_b;
  logic [7:0]          nxt_b;
  sfd_pkg::sfd_stat_t  stat;
  sfd_pkg::sfd_stat_t  wdat;
  sfd_pkg::sfd_dcfg_t  dcfg;
  logic [7:0]          pcnt;
  logic                unl_v;
  logic [11:0]         unl_sec;
  logic [sfd_pkg::MEM_AW-1:0] mptr;
  logic [7:0]          mem [0:(1<<sfd_pkg::MEM_AW)-1];
  logic                fin;
  logic                do_write_enable_cmd;
  logic                do_unlk;
  logic                do_lock;
  logic                wr_stat;

  // ==========================================================
  // pin synchronisers and edge finders
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_s <= 3'h0;
      ce_s  <= 2'h3;
      ce_q  <= 1'b1;
      io_m  <= 4'h0;
      io_s  <= 4'h0;
    end else begin
      sck_s <= {sck_s[1:0], sck};
      ce_s  <= {ce_s[0], ce_b};
      ce_q  <= ce_s[1];
      io_m  <= io_i;
      io_s  <= io_m;
    end
  end

  assign rise    = sck_s[1] & ~sck_s[2];
  assign fall    = ~sck_s[1] & sck_s[2];
  assign ce_fall = ~ce_s[1] & ce_q;
  assign ce_rise = ce_s[1] & ~ce_q;

  // ==========================================================
  // phase lengths and datapath terms
  assign bpe    = sfd_bpe(ln);
  assign cmd_n  = {cmd[6:0], io_s[0]};
  assign adr_n  = adr + 24'h000001;
  assign adr_in = sfd_shin(ln, adr, io_s);
  assign mode_w = sfd_shin(ln, {16'h0000, mode}, io_s);
  assign cur_b  = mem[adr[sfd_pkg::MEM_AW-1:0]];
  assign nxt_b  = mem[adr_n[sfd_pkg::MEM_AW-1:0]];
  assign mode_f = (ecnt < mlen) ? mode_w[7:0] : mode;

  // double-rate address starts on a rising edge, so the fall after the opcode is skipped
  assign in_edge  = rise | (dtr & fall & ~(st == sfd_pkg::S_ADDR && ecnt == 6'h00));
  assign out_edge = dtr ? (rise | fall) : fall;

  always_comb begin
    alen = sfd_pkg::ADR_X1;
    dlen = sfd_pkg::INFO_DUMMY;
    mlen = 6'h00;
    if (dtr) begin
      case (ln)
        sfd_pkg::LN_2: begin
          alen = sfd_pkg::ADR_X2;
          dlen = {1'b0, dcfg.dual, 1'b0};
          mlen = sfd_pkg::MODE_X2;
        end
        sfd_pkg::LN_4: begin
          alen = sfd_pkg::ADR_X4;
          dlen = {1'b0, dcfg.quad, 1'b0};
          mlen = sfd_pkg::MODE_X4;
        end
        default: begin
          dlen = sfd_pkg::FDTR_DUMMY;
        end
      endcase
    end
  end

  // ==========================================================
  // command engine and data pins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st      <= sfd_pkg::S_IDLE;
      ln      <= sfd_pkg::LN_1;
      cont_ln <= sfd_pkg::LN_1;
      dtr     <= 1'b0;
      cont    <= 1'b0;
      cmd     <= 8'h00;
      ecnt    <= 6'h00;
      rcnt    <= 6'h00;
      adr     <= 24'h000000;
      mode    <= 8'h00;
      sh      <= 8'h00;
      nb      <= 4'h0;
      io_o    <= 4'h0;
      io_oe_b <= sfd_pkg::OE_OFF;
    end else if (ce_s[1]) begin
      st      <= sfd_pkg::S_IDLE;
      ecnt    <= 6'h00;
      io_o    <= 4'h0;
      io_oe_b <= sfd_pkg::OE_OFF;
    end else if (ce_fall) begin
      ecnt <= 6'h00;
      rcnt <= 6'h00;
      if (cont) begin
        st  <= stat.busy ? sfd_pkg::S_SKIP : sfd_pkg::S_ADDR;
        ln  <= cont_ln;
        dtr <= 1'b1;
      end else begin
        st  <= sfd_pkg::S_CMD;
        ln  <= sfd_pkg::LN_1;
        dtr <= 1'b0;
      end
    end else begin
      if (rise && rcnt != sfd_pkg::RCNT_MAX) begin
        rcnt <= rcnt + 6'h01;
      end
      case (st)
        sfd_pkg::S_CMD: begin
          if (rise) begin
            cmd  <= cmd_n;
            ecnt <= ecnt + 6'h01;
            if (ecnt == sfd_pkg::CMD_EDGES - 6'h01) begin
              ecnt <= 6'h00;
              st   <= sfd_pkg::S_SKIP;
              case (cmd_n)
                sfd_pkg::OP_INFO: begin
                  if (!stat.busy) st <= sfd_pkg::S_ADDR;
                end
                sfd_pkg::OP_FDTR: begin
                  if (!stat.busy) st <= sfd_pkg::S_ADDR;
                  dtr <= 1'b1;
                end
                sfd_pkg::OP_DDTR: begin
                  if (!stat.busy) st <= sfd_pkg::S_ADDR;
                  dtr <= 1'b1;
                  ln  <= sfd_pkg::LN_2;
                end
                sfd_pkg::OP_QDTR: begin
                  if (!stat.busy && stat.qe) st <= sfd_pkg::S_ADDR;
                  dtr <= 1'b1;
                  ln  <= sfd_pkg::LN_4;
                end
                sfd_pkg::OP_UNLK, sfd_pkg::OP_WRITE_ENABLE_CMD, sfd_pkg::OP_LOCK: begin
                  st <= sfd_pkg::S_HOLD;
                end
                default: begin
                  st <= sfd_pkg::S_SKIP;
                end
              endcase
            end
          end
        end
        sfd_pkg::S_ADDR: begin
          if (in_edge) begin
            adr  <= adr_in;
            ecnt <= ecnt + 6'h01;
            if (ecnt == alen - 6'h01) begin
              ecnt <= 6'h00;
              mode <= 8'h00;
              st   <= sfd_pkg::S_DUMMY;
            end
          end
        end
        sfd_pkg::S_DUMMY: begin
          // pins stay released here: the host's mode nibble shares these clocks
          if (in_edge) begin
            ecnt <= ecnt + 6'h01;
            mode <= mode_f;
            if (ecnt == dlen - 6'h01) begin
              ecnt <= 6'h00;
              st   <= sfd_pkg::S_DATA;
              if (dtr && ln != sfd_pkg::LN_1) begin
                cont    <= (mode_f[7:4] == sfd_pkg::MODE_CONT);
                cont_ln <= ln;
              end
              if (dtr) begin
                io_o    <= sfd_lanes(ln, cur_b);
                io_oe_b <= sfd_oe(ln);
                sh      <= cur_b << bpe;
                nb      <= bpe;
              end else begin
                sh <= cur_b;
                nb <= 4'h0;
              end
            end
          end
        end
        sfd_pkg::S_DATA: begin
          if (out_edge) begin
            io_oe_b <= sfd_oe(ln);
            if (nb == sfd_pkg::BYTE_BITS) begin
              adr  <= adr_n;
              io_o <= sfd_lanes(ln, nxt_b);
              sh   <= nxt_b << bpe;
              nb   <= bpe;
            end else begin
              io_o <= sfd_lanes(ln, sh);
              sh   <= sh << bpe;
              nb   <= nb + bpe;
            end
          end
        end
        sfd_pkg::S_HOLD: begin
          if (rise) adr <= adr_in;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // frame-end actions of the write-enable, unlock and relock frames
  assign fin     = ce_rise && st == sfd_pkg::S_HOLD;
  assign do_write_enable_cmd = fin && cmd == sfd_pkg::OP_WRITE_ENABLE_CMD && rcnt == sfd_pkg::CMD_EDGES;
  assign do_lock = fin && cmd == sfd_pkg::OP_LOCK && rcnt == sfd_pkg::CMD_EDGES;
  assign do_unlk = fin && cmd == sfd_pkg::OP_UNLK
                   && rcnt == sfd_pkg::UNLK_EDGES
                   && adr[11:0] == sfd_pkg::SECT_OFS
                   && stat.wel && (stat.bp != 4'h0)
                   && !unl_v;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      unl_v   <= 1'b0;
      unl_sec <= 12'h000;
    end else if (do_lock) begin
      unl_v <= 1'b0;
    end else if (do_unlk) begin
      unl_v   <= 1'b1;
      unl_sec <= adr[23:12];
    end
  end

  // ==========================================================
  // status: busy timer and write-enable latch
  assign wr_stat = reg_wr && reg_addr == sfd_pkg::REG_STATUS;
  assign wdat    = sfd_pkg::sfd_stat_t'(reg_wdata[6:0]);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat <= '0;
      pcnt <= 8'h00;
    end else begin
      if (wr_stat) begin
        stat.qe  <= wdat.qe;
        stat.bp  <= wdat.bp;
        stat.wel <= wdat.wel;
      end
      if (wr_stat && wdat.busy && !stat.busy) begin
        stat.busy <= 1'b1;
        pcnt      <= 8'(sfd_pkg::PROG_CYC);
      end else if (pcnt != 8'h00) begin
        pcnt <= pcnt - 8'h01;
        if (pcnt == 8'h01) stat.busy <= 1'b0;
      end
      if (do_unlk) stat.wel <= 1'b0;
      // the latch set wins over any clear in the same cycle
      if (do_write_enable_cmd) stat.wel <= 1'b1;
    end
  end

  // ==========================================================
  // register port and read-data memory
  always_ff @(posedge ref_clk) begin
    if (reg_wr && reg_addr == sfd_pkg::REG_MDATA) mem[mptr] <= reg_wdata;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dcfg      <= {sfd_pkg::QDUMMY_RST, sfd_pkg::DDUMMY_RST};
      mptr      <= '0;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == sfd_pkg::REG_DUMMY) dcfg <= reg_wdata;
      if (reg_wr && reg_addr == sfd_pkg::REG_MPTR) begin
        mptr <= reg_wdata[sfd_pkg::MEM_AW-1:0];
      end else if (reg_wr && reg_addr == sfd_pkg::REG_MDATA) begin
        mptr <= mptr + 1'b1;
      end
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          sfd_pkg::REG_STATUS:  reg_rdata <= {1'b0, stat};
          sfd_pkg::REG_DUMMY:   reg_rdata <= dcfg;
          sfd_pkg::REG_MPTR:    reg_rdata <= 8'(mptr);
          sfd_pkg::REG_MDATA:   reg_rdata <= mem[mptr];
          sfd_pkg::REG_LOCK:    reg_rdata <= {6'h00, cont, unl_v};
          sfd_pkg::REG_SECT_HI: reg_rdata <= unl_sec[11:4];
          sfd_pkg::REG_SECT_LO: reg_rdata <= {4'h0, unl_sec[3:0]};
          default:              reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_sdr_fall;
    (st == sfd_pkg::S_DATA && !dtr && !ce_s[1] && $changed(io_o)) |-> $past(fall);
  endproperty
  a_sdr_fall: assert property (p_sdr_fall) else $error("sdr data moved off a fall");

  property p_info_inc;
    (st == sfd_pkg::S_DATA && !dtr && out_edge && nb == 4'h8 && !ce_s[1])
      |=> adr == $past(adr) + 24'h000001;
  endproperty
  a_info_inc: assert property (p_info_inc) else $error("info address not stepped");

  property p_dtr_inc;
    (st == sfd_pkg::S_DATA && dtr && out_edge && nb == 4'h8 && !ce_s[1])
      |=> adr == $past(adr) + 24'h000001 ##1 nb == $past(bpe, 2);
  endproperty
  a_dtr_inc: assert property (p_dtr_inc) else $error("dtr address not stepped");

  property p_info_busy;
    (st == sfd_pkg::S_CMD && rise && ecnt == 6'h07 && !ce_s[1]
      && cmd_n == sfd_pkg::OP_INFO && stat.busy) |=> st == sfd_pkg::S_SKIP [*2];
  endproperty
  a_info_busy: assert property (p_info_busy) else $error("busy info read accepted");

  property p_quad_busy;
    (st == sfd_pkg::S_CMD && rise && ecnt == 6'h07 && !ce_s[1]
      && cmd_n == sfd_pkg::OP_QDTR && stat.busy) |=> st == sfd_pkg::S_SKIP;
  endproperty
  a_quad_busy: assert property (p_quad_busy) else $error("busy quad read accepted");

  property p_release;
    ce_s[1] |=> io_oe_b == sfd_pkg::OE_OFF && st == sfd_pkg::S_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("pins driven while deselected");

  property p_cont;
    (st == sfd_pkg::S_DUMMY && in_edge && ecnt == dlen - 6'h01 && dtr
      && ln != sfd_pkg::LN_1 && !ce_s[1])
      |=> cont == ($past(mode_f[7:4]) == sfd_pkg::MODE_CONT);
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode not tracked");

  property p_unlk_ofs;
    (fin && cmd == sfd_pkg::OP_UNLK && adr[11:0] != 12'h000 && !unl_v) |=> !unl_v;
  endproperty
  a_unlk_ofs: assert property (p_unlk_ofs) else $error("unaligned sector unlocked");

  property p_unlk_cnt;
    (fin && cmd == sfd_pkg::OP_UNLK && rcnt != 6'h20 && !unl_v) |=> !unl_v;
  endproperty
  a_unlk_cnt: assert property (p_unlk_cnt) else $error("short unlock frame accepted");

  property p_unlk_bp;
    (fin && cmd == sfd_pkg::OP_UNLK && stat.bp == 4'h0 && !unl_v) |=> !unl_v;
  endproperty
  a_unlk_bp: assert property (p_unlk_bp) else $error("unlock without protection");

  property p_one_sector;
    (unl_v && !do_lock) |=> unl_v && $stable(unl_sec);
  endproperty
  a_one_sector: assert property (p_one_sector) else $error("second sector unlocked");

  property p_busy_hold;
    (wr_stat && wdat.busy && !stat.busy) |=> stat.busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_quad_pins;
    (st == sfd_pkg::S_DATA && ln == sfd_pkg::LN_4 && !ce_s[1]) |-> io_oe_b == 4'h0;
  endproperty
  a_quad_pins: assert property (p_quad_pins) else $error("quad data not on four lines");

endmodule : sfd_top

// ---- verif/sfd_host.sv ----
// sfd_host: link-side host model that clocks frames into the slave
// assumes a 25 MHz ref_clk; one sck edge every four ref_clk cycles
`timescale 1ns/10ps
module sfd_host (
  input  wire logic       ref_clk,
  input  wire logic [3:0] io_o,
  input  wire logic [3:0] io_oe_b,
  output logic            ce_b,
  output logic            sck,
  output logic      [3:0] io_h
);
  initial begin
    ce_b = 1'b1;
    sck  = 1'b0;
    io_h = 4'h0;
  end
  // ==========================================================
  // one edge; data is set up two cycles ahead of it and held two cycles past it
  // o holds what the slave showed after the edge before the previous one
  task automatic tick(input logic s, input logic r, input logic [3:0] v,
                      output logic [7:0] o);
    @(posedge ref_clk);
    o = {io_oe_b, io_o};
    io_h <= r ? ~io_h : v;
    repeat (2) @(posedge ref_clk);
    sck <= s;
    @(posedge ref_clk);
  endtask : tick
  task automatic frame(input logic lo);
    @(posedge ref_clk);
    ce_b <= lo;
    repeat (4) @(posedge ref_clk);
  endtask : frame
endmodule : sfd_host

// ---- verif/tb_top.sv ----
// tb_top: self-checking bench for the serial flash read and unlock slave
// assumes sfd_top and the sfd_host link model are compiled before it
`timescale 1ns/10ps
module tb_top;
  logic        ref_clk, rst_b, ce_b, sck, reg_wr, reg_rd, lvl, idle_all;
  logic [3:0]  io_h, io_o, io_oe_b, io_i, oe_first;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, o;
  logic [15:0] got;
  logic [5:0]  q[$];
  logic [7:0]  cap[$];
  int          err_total = 0;
  int          cmp_count = 0;
  // released lines show the host value, driven lines the slave value
  assign io_i = (io_oe_b & io_h) | (~io_oe_b & io_o);
  sfd_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce_b(ce_b), .sck(sck), .io_i(io_i),
    .io_o(io_o), .io_oe_b(io_oe_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  sfd_host u_host (.ref_clk(ref_clk), .io_o(io_o), .io_oe_b(io_oe_b), .ce_b(ce_b),
    .sck(sck), .io_h(io_h));
  // ==========================================================
  // checks and register port
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(n, reg_rdata, e);
  endtask : rd
  // ==========================================================
  // frame building: {release, sck level, io value} per edge
  task automatic put(input logic [23:0] d, input int n, input int w, input bit sdr,
                     input bit r);
    for (int i = n - w; i >= 0; i -= w) begin
      repeat (sdr ? 2 : 1) begin
        lvl = ~lvl;
        q.push_back({r, lvl, 4'(d >> i) & 4'((1 << w) - 1)});
      end
    end
  endtask : put
  task automatic go(input int f, input int st, input int w);
    repeat (2) q.push_back({1'b1, lvl, 4'h0});
    cap.delete();
    idle_all = 1'b1;
    u_host.frame(1'b0);
    foreach (q[i]) begin
      u_host.tick(q[i][4], q[i][5], q[i][3:0], o);
      cap.push_back(o);
      idle_all &= (o[7:4] === 4'hf);
    end
    u_host.frame(1'b1);
    got = 16'h0;
    for (int k = 0; k < 16 / w; k++) begin
      // cap[j] shows the slave as it stood after edge j - 2
      o = cap[f + k * st + 2];
      got = (got << w) | 16'((w == 1 ? o[3:1] : o[3:0]) & 4'((1 << w) - 1));
    end
    oe_first = cap[f + 2][7:4];
  endtask : go
  task automatic dr(input logic [7:0] op, input bit c, input int w, input logic [3:0] md);
    int d;
    d = (w == 1) ? 8 : (w == 2 ? 4 : 6);
    q.delete();
    lvl = 1'b0;
    if (!c) put(op, 8, 1, 1, 0);
    put(24'hffffff, 24, w, 0, 0);
    put(md, 4, w, 0, 0);
    put(0, d - 4 / w, 1, 0, 1);
    put(0, 16 / w, 1, 0, 1);
    go((c ? 0 : 16) + 24 / w + d - 1, 1, w);
  endtask : dr
  task automatic unl(input logic [7:0] op, input logic [23:0] a, input int n);
    q.delete();
    lvl = 1'b0;
    put(op, 8, 1, 1, 0);
    put(a, n, 1, 1, 0);
    go(0, 1, 1);
  endtask : unl
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd(3'h0, 8'h00, "status");
    rd(3'h1, 8'h32, "dummy cfg");
    wr(3'h1, 8'h43);
    rd(3'h1, 8'h43, "dummy wr");
    wr(3'h1, 8'h32);
    rd(3'h7, 8'h00, "unmapped");
    wr(3'h2, 8'h3f);
    wr(3'h3, 8'hc5);
    wr(3'h3, 8'h3a);
    rd(3'h2, 8'h01, "ptr wrap");
    wr(3'h2, 8'h00);
    rd(3'h3, 8'h3a, "mem wrap");
  endtask : t_regs
  task automatic t_info();
    q.delete();
    lvl = 1'b0;
    put(8'h68, 8, 1, 1, 0);
    put(24'hffffff, 24, 1, 1, 0);
    put(0, 8, 1, 1, 1);
    put(0, 16, 1, 1, 1);
    go(79, 2, 1);
    chk("info data", got, 16'hc53a);
    chk("info oe", oe_first, 4'hd);
    chk("info end", io_oe_b, 4'hf);
  endtask : t_info
  task automatic t_reads();
    dr(8'h0d, 0, 1, 4'h0);
    chk("fdtr data", got, 16'hc53a);
    chk("fdtr oe", oe_first, 4'hd);
    chk("fdtr end", io_oe_b, 4'hf);
    dr(8'hbd, 0, 2, 4'ha);
    chk("dual data", got, 16'hc53a);
    chk("dual oe", oe_first, 4'hc);
    rd(3'h4, 8'h02, "cont on");
    dr(8'hbd, 1, 2, 4'h0);
    chk("dual cont", got, 16'hc53a);
    dr(8'hbd, 0, 2, 4'h0);
    chk("dual exit", got, 16'hc53a);
    wr(3'h0, 8'h40);
    dr(8'hed, 0, 4, 4'ha);
    chk("quad data", got, 16'hc53a);
    chk("quad oe", oe_first, 4'h0);
    dr(8'hed, 1, 4, 4'h0);
    chk("quad cont", got, 16'hc53a);
    rd(3'h4, 8'h00, "cont off");
  endtask : t_reads
  task automatic t_busy();
    logic [7:0] ops [4];
    ops = '{8'h68, 8'h0d, 8'hbd, 8'hed};
    foreach (ops[j]) begin
      wr(3'h0, 8'h41);
      if (j == 0) rd(3'h0, 8'h41, "busy set");
      q.delete();
      lvl = 1'b0;
      put(ops[j], 8, 1, 1, 0);
      put(24'hffffff, 24, 1, 1, 0);
      put(0, 24, 1, 0, 1);
      go(0, 1, 1);
      chk("busy idle", idle_all, 1'b1);
    end
    rd(3'h0, 8'h40, "busy done");
  endtask : t_busy
  task automatic t_unlock();
    logic [23:0] ad [5];
    logic [7:0]  st [5];
    int          nb [5];
    ad = '{24'h123000, 24'h123001, 24'h123000, 24'h123000, 24'h456000};
    st = '{8'h40, 8'h44, 8'h44, 8'h44, 8'h44};
    nb = '{24, 24, 23, 24, 24};
    foreach (ad[j]) begin
      wr(3'h0, st[j]);
      unl(8'h06, 24'h0, 0);
      unl(8'h26, ad[j], nb[j]);
      rd(3'h4, {7'h0, j > 2}, "unlocked");
    end
    rd(3'h5, 8'h12, "sector hi");
    rd(3'h6, 8'h03, "sector lo");
    unl(8'h24, 24'h0, 0);
    rd(3'h4, 8'h00, "relocked");
  endtask : t_unlock
  // ==========================================================
  // clock, reset, sequence and verdict
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_info();
    t_reads();
    t_busy();
    t_unlock();
    print_verdict();
  end
endmodule : tb_top
